// file: hdbp_partitioner.sv
// Purpose: resamples active video and tags every luma sample with its block position
// Assumes: source logic on the same clock; mode_select is a static pin
// Notes:   tags describe luma samples; chroma travels on out_c_valid
// Functional notes
// - 1080/50 resamples luma 1920 to 1440, chroma 960 to 720.
// - 720 modes resample luma 1280 to 960, chroma 640 to 480.
// - resampled samples keep at least eight bits.
// - active lines 21-560 and 584-1123, or 26-745 for 720 modes.
// - planes split into 8x8 blocks, counted from left and top.
// - 1080 blocks: even rows field one, odd rows field two.
// - 1080/60: 135 block rows, 160 luma and 80 chroma blocks.
// - 1080/50: 135 block rows, 180 luma and 90 chroma blocks.
// - 720: 90 block rows, 120 luma and 60 chroma blocks.
// - macro block: 2x2 luma blocks plus two vertical chroma pairs.
// - 1080 bottom macro row uses horizontal blocks: 40 or 45.
// - 1080/60: 67 rows of 80 plus bottom 40, 5400 total.
// - 1080/60 leftover set rearranged into 4 by 10 grid.
// - 1080/50: 67 rows of 90 plus bottom 45, 6075 total.
// - 1080/50: edge unit 135 macro blocks, main unit 66 by 90.
// - 720: 45 rows by 60 macro blocks.
// - 1080/60: groups of nine, divided block by row and group parity.
// - 1080/50 main unit: groups of nine, divided by parities.
// - 720: groups of six, odd frames map to upper divided blocks.
// - 1080/60 resamples luma 1920 to 1280, chroma 960 to 640.
// - input samples become two's complement by inverting the MSB.
`include "hdbp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module hdbp_partitioner (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // mode pin
  input  wire logic [1:0]  mode_select,
  // source stream
  input  wire logic        pix_valid,
  input  wire logic        pix_sof,
  input  wire logic        pix_sol,
  input  wire logic        pix_active,
  input  wire logic [9:0]  pix_y,
  input  wire logic [9:0]  pix_cb,
  input  wire logic [9:0]  pix_cr,
  // resampled samples
  output logic             out_valid,
  output logic      [9:0]  out_y,
  output logic             out_c_valid,
  output logic      [9:0]  out_cb,
  output logic      [9:0]  out_cr,
  // position tags of out_y
  output logic      [7:0]  blk_col,
  output logic      [7:0]  blk_row,
  output logic      [2:0]  blk_xpos,
  output logic      [2:0]  blk_ypos,
  output logic      [6:0]  mb_row,
  output logic      [6:0]  mb_col,
  output logic             leftover,
  output logic      [1:0]  grid_row,
  output logic      [3:0]  grid_col,
  output logic             edge_unit,
  output logic      [1:0]  div_block,
  // status
  output logic      [1:0]  active_mode,
  output logic             line_len_err,
  output logic             frame_len_err
);

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic group_odd(input logic [6:0] col, input logic [6:0] size);
    logic [6:0] q;
    q = col / size;
    return q[0];
  endfunction : group_odd

  function automatic logic [11:0] line_total(input hdbp_pkg::hdbp_mode_type m);
    case (m)
      hdbp_pkg::HDBP_M1080_60: line_total = `HDBP_TOT_1080_60;
      hdbp_pkg::HDBP_M1080_50: line_total = `HDBP_TOT_1080_50;
      hdbp_pkg::HDBP_M720_60:  line_total = `HDBP_TOT_720_60;
      default:                 line_total = `HDBP_TOT_720_50;
    endcase
  endfunction : line_total

  function automatic logic [7:0] col_limit(input hdbp_pkg::hdbp_mode_type m);
    case (m)
      hdbp_pkg::HDBP_M1080_60: col_limit = `HDBP_BCOLS_1080_60;
      hdbp_pkg::HDBP_M1080_50: col_limit = `HDBP_BCOLS_1080_50;
      default:                 col_limit = `HDBP_BCOLS_720;
    endcase
  endfunction : col_limit

  // ****************************************
  // mode pin synchroniser and frame control
  // ****************************************
  logic [1:0]              mode_meta;
  logic [1:0]              mode_sync;
  hdbp_pkg::hdbp_mode_type mode;
  hdbp_pkg::hdbp_mode_type next_mode;
  logic [11:0]             samp_cnt;
  logic [11:0]             next_samp_cnt;
  logic [10:0]             line_cnt;
  logic [10:0]             next_line_cnt;
  logic                    line_seen;
  logic                    next_line_seen;
  logic                    frame_seen;
  logic                    next_frame_seen;
  logic                    frame_odd;
  logic                    next_frame_odd;
  logic                    c_phase;
  logic                    next_c_phase;
  logic                    next_line_len_err;
  logic                    next_frame_len_err;
  logic                    is1080;
  logic                    in_lines;
  logic                    field2;
  logic [10:0]             row;
  logic                    take;

  assign is1080 = !mode[1];
  assign field2 = line_cnt >= `HDBP_F2_FIRST;

  // active line windows per field or frame
  always_comb begin
    if (is1080) begin
      in_lines = (line_cnt >= `HDBP_F1_FIRST && line_cnt <= `HDBP_F1_LAST) ||
                 (line_cnt >= `HDBP_F2_FIRST && line_cnt <= `HDBP_F2_LAST);
      // field one on even rows of each block, field two on odd
      row = field2 ? 11'((line_cnt - `HDBP_F2_FIRST) * 2 + 1)
                   : 11'((line_cnt - `HDBP_F1_FIRST) * 2);
    end else begin
      in_lines = line_cnt >= `HDBP_P_FIRST && line_cnt <= `HDBP_P_LAST;
      row      = line_cnt - `HDBP_P_FIRST;
    end
  end

  assign take = pix_valid && pix_active && in_lines && !pix_sol;

  always_comb begin
    next_mode          = mode;
    next_samp_cnt      = samp_cnt;
    next_line_cnt      = line_cnt;
    next_line_seen     = line_seen;
    next_frame_seen    = frame_seen;
    next_frame_odd     = frame_odd;
    next_c_phase       = c_phase;
    next_line_len_err  = line_len_err;
    next_frame_len_err = frame_len_err;
    if (pix_valid) begin
      next_samp_cnt = pix_sol ? 12'h0_001 : 12'(samp_cnt + 12'h0_001);
      next_c_phase  = take ? !c_phase : c_phase;
      if (pix_sof) begin
        // a new mode only takes hold at a frame boundary
        next_mode          = hdbp_pkg::hdbp_mode_type'(mode_sync);
        next_line_cnt      = 11'h001;
        next_frame_odd     = !frame_odd;
        next_frame_seen    = 1'b1;
        next_line_len_err  = 1'b0;
        next_frame_len_err = 1'b0;
        if (frame_seen) begin
          next_frame_len_err = line_cnt != (is1080 ? `HDBP_LINES_1080 : `HDBP_LINES_720);
        end
      end else if (pix_sol) begin
        next_line_cnt = 11'(line_cnt + 11'h001);
      end
      if (pix_sol) begin
        next_line_seen = 1'b1;
        next_c_phase   = 1'b0;
        // every completed line must match the mode's total
        if (line_seen && samp_cnt != line_total(mode)) begin
          next_line_len_err = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mode_meta     <= 2'h0;
      mode_sync     <= 2'h0;
      mode          <= hdbp_pkg::HDBP_M1080_60;
      samp_cnt      <= 12'h0_000;
      line_cnt      <= 11'h000;
      line_seen     <= 1'b0;
      frame_seen    <= 1'b0;
      frame_odd     <= 1'b1;
      c_phase       <= 1'b0;
      line_len_err  <= 1'b0;
      frame_len_err <= 1'b0;
    end else begin
      mode_meta     <= mode_select;
      mode_sync     <= mode_meta;
      mode          <= next_mode;
      samp_cnt      <= next_samp_cnt;
      line_cnt      <= next_line_cnt;
      line_seen     <= next_line_seen;
      frame_seen    <= next_frame_seen;
      frame_odd     <= next_frame_odd;
      c_phase       <= next_c_phase;
      line_len_err  <= next_line_len_err;
      frame_len_err <= next_frame_len_err;
    end
  end

  assign active_mode = mode;

  // ****************************************
  // resamplers, one per component
  // ****************************************
  logic [2:0]  num;
  logic [2:0]  den;
  logic [29:0] comp_in;
  logic [2:0]  comp_in_valid;
  logic [2:0]  comp_out_valid;
  logic [29:0] comp_out;

  // 1080/60 uses two thirds, the other modes three quarters
  assign num = (mode == hdbp_pkg::HDBP_M1080_60) ? `HDBP_NUM_2_3 : `HDBP_NUM_3_4;
  assign den = (mode == hdbp_pkg::HDBP_M1080_60) ? `HDBP_DEN_2_3 : `HDBP_DEN_3_4;
  assign comp_in = {~pix_cr[9], pix_cr[8:0], ~pix_cb[9], pix_cb[8:0], ~pix_y[9], pix_y[8:0]};
  // chroma is co-sited with even luma samples
  assign comp_in_valid = {{2{take && !c_phase}}, take};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_comp
      hdbp_resampler u_rs (
        .clock      (clock),
        .reset      (reset),
        .line_start (pix_valid && pix_sol),
        .ratio_num  (num),
        .ratio_den  (den),
        .in_valid   (comp_in_valid[gi]),
        .in_sample  (comp_in[gi*10 +: 10]),
        .out_valid  (comp_out_valid[gi]),
        .out_sample (comp_out[gi*10 +: 10])
      );
    end
  endgenerate

  // ****************************************
  // block and macro block tagging
  // ****************************************
  logic [10:0] xo;
  logic [10:0] next_xo;
  logic [10:0] row_q;
  logic        field2_q;
  logic        bottom;
  logic [6:0]  t_mb_row;
  logic [6:0]  t_mb_col;
  logic [6:0]  t_grid_row;
  logic [6:0]  t_grid_col;
  logic [6:0]  main_row;

  always_comb begin
    next_xo = xo;
    if (pix_valid && pix_sol) begin
      next_xo = 11'h000;
    end else if (comp_out_valid[0]) begin
      next_xo = 11'(xo + 11'h001);
    end
  end

  // 2x2 luma blocks span 16 columns and 2 block rows
  always_comb begin
    bottom     = is1080 && row_q[10:3] == `HDBP_BOTTOM_BROW;
    // bottom macro blocks are four blocks wide, one high
    t_mb_row   = bottom ? `HDBP_BOTTOM_MBROW : row_q[10:4];
    t_mb_col   = bottom ? xo[10:5] : xo[10:4];
    // leftover index folded into rows of ten
    t_grid_row = t_mb_col / `HDBP_GRID_COLS;
    t_grid_col = t_mb_col % `HDBP_GRID_COLS;
    main_row   = 7'(t_mb_row - 7'h01);
  end

  logic       next_leftover;
  logic       next_edge;
  logic [1:0] next_div;

  always_comb begin
    next_leftover = 1'b0;
    next_edge     = 1'b0;
    case (mode)
      hdbp_pkg::HDBP_M1080_60: begin
        // 67 regular rows then the bottom leftover row
        next_leftover = bottom;
        // row parity and nine-wide group parity
        next_div = bottom ? {t_grid_row[0], 1'b0}
                          : {t_mb_row[0], group_odd(t_mb_col, `HDBP_GROUP_1080)};
      end
      hdbp_pkg::HDBP_M1080_50: begin
        // 67 regular rows then a bottom row of 45
        // top row and bottom row form the edge unit
        next_edge = t_mb_row == 7'h00 || bottom;
        // main unit rows counted from the second row
        next_div  = next_edge ? 2'h0
                              : {main_row[0], group_odd(t_mb_col, `HDBP_GROUP_1080)};
      end
      default: begin
        // 45 by 60 grid, no bottom row
        // odd frames go to divided blocks two and three
        next_div = {frame_odd, group_odd(t_mb_col, `HDBP_GROUP_720)};
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      xo          <= 11'h000;
      row_q       <= 11'h000;
      field2_q    <= 1'b0;
      out_valid   <= 1'b0;
      out_y       <= 10'h000;
      out_c_valid <= 1'b0;
      out_cb      <= 10'h000;
      out_cr      <= 10'h000;
      blk_col     <= 8'h00;
      blk_row     <= 8'h00;
      blk_xpos    <= 3'h0;
      blk_ypos    <= 3'h0;
      mb_row      <= 7'h00;
      mb_col      <= 7'h00;
      leftover    <= 1'b0;
      grid_row    <= 2'h0;
      grid_col    <= 4'h0;
      edge_unit   <= 1'b0;
      div_block   <= 2'h0;
    end else begin
      xo          <= next_xo;
      row_q       <= take ? row : row_q;
      field2_q    <= take ? field2 : field2_q;
      out_valid   <= comp_out_valid[0];
      out_c_valid <= comp_out_valid[1];
      if (comp_out_valid[0]) begin
        out_y     <= comp_out[9:0];
        // block column and row from left and top
        blk_col   <= xo[10:3];
        blk_row   <= row_q[10:3];
        blk_xpos  <= xo[2:0];
        blk_ypos  <= row_q[2:0];
        mb_row    <= t_mb_row;
        mb_col    <= t_mb_col;
        leftover  <= next_leftover;
        grid_row  <= next_leftover ? t_grid_row[1:0] : 2'h0;
        grid_col  <= next_leftover ? t_grid_col[3:0] : 4'h0;
        edge_unit <= next_edge;
        div_block <= next_div;
      end
      if (comp_out_valid[1]) begin
        out_cb    <= comp_out[19:10];
        out_cr    <= comp_out[29:20];
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_line_len_flag : assert property (@(posedge clock) disable iff (reset)
    pix_valid && pix_sol && !pix_sof && line_seen && samp_cnt != line_total(mode)
    |=> line_len_err)
    else $error("short or long line not flagged");

  a_mode_frame_hold : assert property (@(posedge clock) disable iff (reset)
    !(pix_valid && pix_sof) |=> $stable(mode))
    else $error("mode changed inside a frame");

  a_block_row_range : assert property (@(posedge clock) disable iff (reset)
    out_valid |-> blk_row < (is1080 ? `HDBP_BROWS_1080 : `HDBP_BROWS_720))
    else $error("block row out of range");

  a_block_col_range : assert property (@(posedge clock) disable iff (reset)
    out_valid |-> blk_col < col_limit(mode))
    else $error("block column out of range");

  a_bottom_mb_shape : assert property (@(posedge clock) disable iff (reset)
    out_valid && is1080 && blk_row == `HDBP_BOTTOM_BROW
    |-> mb_row == `HDBP_BOTTOM_MBROW &&
        mb_col < (mode == hdbp_pkg::HDBP_M1080_60 ? `HDBP_LEFT_60 : `HDBP_LEFT_50))
    else $error("bottom macro block misplaced");

  a_leftover_grid : assert property (@(posedge clock) disable iff (reset)
    out_valid && leftover |-> grid_row * 10 + grid_col == mb_col && grid_col < 4'hA)
    else $error("leftover grid position wrong");

  a_main_unit_rows : assert property (@(posedge clock) disable iff (reset)
    out_valid && mode == hdbp_pkg::HDBP_M1080_50 && !edge_unit
    |-> mb_row >= 7'h01 && mb_row <= `HDBP_MAIN_LAST)
    else $error("main unit row out of range");

  a_field_rows : assert property (@(posedge clock) disable iff (reset)
    out_valid && is1080 |-> blk_ypos[0] == field2_q)
    else $error("field interleave broken");

  a_div_frame_720 : assert property (@(posedge clock) disable iff (reset)
    out_valid && !is1080 |-> div_block[1] == frame_odd)
    else $error("720 frame parity not in divided block");

  a_msb_inverted : assert property (@(posedge clock) disable iff (reset)
    take |-> comp_in[9] != pix_y[9])
    else $error("luma msb not inverted");

endmodule : hdbp_partitioner

`default_nettype wire

// file: hdbp_consts.svh
// Purpose: shared numeric constants of the video block partitioner
// Assumes: pixel sample clock domain only
// Notes:   definitions only
`ifndef HDBP_CONSTS_SVH
`define HDBP_CONSTS_SVH

// ****************************************
// line geometry
// ****************************************
`define HDBP_TOT_1080_60   12'h0_898
`define HDBP_TOT_1080_50   12'h0_A50
`define HDBP_TOT_720_60    12'h0_672
`define HDBP_TOT_720_50    12'h0_7BC
`define HDBP_LINES_1080    11'h465
`define HDBP_LINES_720     11'h2EE
`define HDBP_F1_FIRST      11'h015
`define HDBP_F1_LAST       11'h230
`define HDBP_F2_FIRST      11'h248
`define HDBP_F2_LAST       11'h463
`define HDBP_P_FIRST       11'h01A
`define HDBP_P_LAST        11'h2E9

// ****************************************
// resampling ratios (out over in)
// ****************************************
`define HDBP_NUM_2_3       3'h2
`define HDBP_DEN_2_3       3'h3
`define HDBP_NUM_3_4       3'h3
`define HDBP_DEN_3_4       3'h4

// ****************************************
// block and macro block geometry
// ****************************************
`define HDBP_BROWS_1080    8'h87
`define HDBP_BROWS_720     8'h5A
`define HDBP_BCOLS_1080_60 8'hA0
`define HDBP_BCOLS_1080_50 8'hB4
`define HDBP_BCOLS_720     8'h78
`define HDBP_BOTTOM_BROW   8'h86
`define HDBP_BOTTOM_MBROW  7'h43
`define HDBP_MAIN_LAST     7'h42
`define HDBP_LEFT_60       7'h28
`define HDBP_LEFT_50       7'h2D
`define HDBP_GRID_COLS     7'h0A
`define HDBP_GROUP_1080    7'h09
`define HDBP_GROUP_720     7'h06

`endif

// file: hdbp_pkg.sv
// Purpose: types of the video block partitioner
// Assumes: nothing
// Notes:   constants live in hdbp_consts.svh
package hdbp_pkg;

  typedef enum logic [1:0] {
    HDBP_M1080_60 = 2'b00,
    HDBP_M1080_50 = 2'b01,
    HDBP_M720_60  = 2'b10,
    HDBP_M720_50  = 2'b11
  } hdbp_mode_type;

endpackage : hdbp_pkg

// file: hdbp_resampler.sv
// Purpose: horizontal rational down-resampler for one colour component
// Assumes: ratio below one, so at most one output per input
// Notes:   two-tap interpolation, full 10-bit output
`timescale 1ns/1ps
`default_nettype none

module hdbp_resampler (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // control
  input  wire logic        line_start,
  input  wire logic [2:0]  ratio_num,
  input  wire logic [2:0]  ratio_den,
  // input samples, two's complement
  input  wire logic        in_valid,
  input  wire logic [9:0]  in_sample,
  // output samples
  output logic             out_valid,
  output logic      [9:0]  out_sample
);

  logic [2:0]  acc;
  logic [9:0]  prev;
  logic [2:0]  next_acc;
  logic [9:0]  next_prev;
  logic        next_out_valid;
  logic [9:0]  next_out_sample;
  logic [3:0]  sum;
  logic [10:0] avg;

  always_comb begin
    sum             = {1'b0, acc} + {1'b0, ratio_num};
    avg             = {prev[9], prev} + {in_sample[9], in_sample};
    next_acc        = acc;
    next_prev       = prev;
    next_out_valid  = 1'b0;
    next_out_sample = out_sample;
    if (line_start && !in_valid) begin
      next_acc  = 3'h0;
      next_prev = 10'h000;
    end else if (in_valid) begin
      next_prev = in_sample;
      // phase accumulator, one output whenever the phase wraps
      if (sum >= {1'b0, ratio_den}) begin
        next_out_valid = 1'b1;
        next_acc       = 3'((sum - {1'b0, ratio_den}));
        // full 10-bit result, never truncated below 8 bits
        next_out_sample = (sum == {1'b0, ratio_den}) ? in_sample : avg[10:1];
      end else begin
        next_acc = sum[2:0];
      end
      if (line_start) begin
        next_acc  = ratio_num;
        next_prev = in_sample;
        next_out_valid  = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      acc        <= 3'h0;
      prev       <= 10'h000;
      out_valid  <= 1'b0;
      out_sample <= 10'h000;
    end else begin
      acc        <= next_acc;
      prev       <= next_prev;
      out_valid  <= next_out_valid;
      out_sample <= next_out_sample;
    end
  end

  // output only follows an accepted input
  a_output_follows_input : assert property (@(posedge clock) disable iff (reset)
    out_valid |-> $past(in_valid))
    else $error("resampler output without input");

endmodule : hdbp_resampler

`default_nettype wire

// file: hdbp_source.sv
// Purpose: model of the upstream 10-bit component video source
// Assumes: requests change just after the rising edge
// Notes:   idle cycles invert the data pins; between lines they keep their last values
`timescale 1ns/1ps
`default_nettype none

module hdbp_source (
  // clock
  input  wire logic       clock,
  // source stream
  output logic            pix_valid,
  output logic            pix_sof,
  output logic            pix_sol,
  output logic            pix_active,
  output logic      [9:0] pix_y,
  output logic      [9:0] pix_cb,
  output logic      [9:0] pix_cr
);
  int ys[$];

  initial begin
    {pix_valid, pix_sof, pix_sol, pix_active} = 4'h0;
    {pix_y, pix_cb, pix_cr} = 30'h0000_0000;
  end

  task automatic line(input bit sof, input int tot, input int act);
    logic [9:0] v;
    for (int i = 0; i < tot; i++) begin
      v = 10'($urandom_range(940, 64));
      @(posedge clock);
      pix_valid  <= 1'b1;
      pix_sof    <= sof && i == 0;
      pix_sol    <= i == 0;
      pix_active <= i > 0 && i <= act;
      pix_y      <= v;
      pix_cb     <= 10'($urandom_range(960, 64));
      pix_cr     <= 10'($urandom_range(960, 64));
      if (i > 0 && i <= act) ys.push_back(int'(v));
    end
  endtask : line

  task automatic idle();
    @(posedge clock);
    pix_valid <= 1'b0;
    pix_y     <= ~pix_y;
    pix_cb    <= ~pix_cb;
    pix_cr    <= ~pix_cr;
  endtask : idle
endmodule : hdbp_source

`default_nettype wire

// file: hdbp_partitioner_test.sv
// Purpose: self-checking bench of the video block partitioner
// Assumes: shortened blanking lines, so each mode reaches its first active line fast
// Notes:   one active line per mode; frames are never complete, so length flags are set, the frame flag from the second frame on
`timescale 1ns/1ps
`default_nettype none

module hdbp_partitioner_test;
  logic       clock;
  logic       reset;
  logic [1:0] mode_select;
  logic       pix_valid, pix_sof, pix_sol, pix_active;
  logic [9:0] pix_y, pix_cb, pix_cr, out_y;
  logic       out_valid, out_c_valid, edge_unit, line_len_err, frame_len_err;
  logic [7:0] blk_col, blk_row;
  logic [2:0] blk_xpos, blk_ypos;
  logic [1:0] div_block, active_mode;
  logic [6:0] mb_row, mb_col;
  logic       leftover;
  int         mismatches, total_checks, nv, nc, grp, hi, acc, k;
  int         tot[4]   = '{2200, 2640, 1650, 1980};
  int         act[4]   = '{1920, 1920, 1280, 1280};
  int         first[4] = '{21, 21, 26, 26};
  int         num[4]   = '{2, 3, 3, 3};
  logic [9:0] gy[$];
  logic signed [9:0] s, prev, e;

  hdbp_source hdbp_source_i (.clock(clock), .pix_valid(pix_valid), .pix_sof(pix_sof),
    .pix_sol(pix_sol), .pix_active(pix_active), .pix_y(pix_y), .pix_cb(pix_cb),
    .pix_cr(pix_cr));

  hdbp_partitioner hdbp_partitioner_i (.clock(clock), .reset(reset),
    .mode_select(mode_select), .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_sol(pix_sol),
    .pix_active(pix_active), .pix_y(pix_y), .pix_cb(pix_cb), .pix_cr(pix_cr),
    .out_valid(out_valid), .out_y(out_y), .out_c_valid(out_c_valid), .out_cb(), .out_cr(),
    .blk_col(blk_col), .blk_row(blk_row), .blk_xpos(blk_xpos), .blk_ypos(blk_ypos),
    .mb_row(mb_row), .mb_col(mb_col), .leftover(leftover), .grid_row(), .grid_col(),
    .edge_unit(edge_unit),
    .div_block(div_block), .active_mode(active_mode), .line_len_err(line_len_err),
    .frame_len_err(frame_len_err));

  task automatic chk(input bit ok, input string what);
    total_checks++;
    if (!ok) begin
      mismatches++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ****************************************
  // output monitor
  // ****************************************
  always @(posedge clock) begin
    if (out_c_valid === 1'b1) nc++;
    if (out_valid === 1'b1) begin
      gy.push_back(out_y);
      chk(blk_xpos === 3'(nv % 8) && blk_col === 8'(nv / 8), "column tag");
      chk(blk_row === 8'h00 && blk_ypos === 3'h0, "row tag");
      chk(mb_row === 7'h00 && mb_col === 7'(nv / 16) && leftover === 1'b0, "mb tag");
      chk(grp == 0 ? edge_unit === 1'b1 && div_block === 2'h0
                   : div_block === 2'(hi + (nv / 16 / grp) % 2), "divided block");
      nv++;
    end
  end

  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    conclude();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset       = 1'b1;
    mode_select = 2'h0;
    void'($urandom(32'h52ca));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      @(posedge clock);
      mode_select <= 2'(m);
      repeat (4) @(posedge clock);
      nv  = 0;
      nc  = 0;
      gy.delete();
      grp = m == 0 ? 9 : (m == 1 ? 0 : 6);
      hi  = m == 3 ? 2 : 0;
      hdbp_source_i.line(1, 3, 1);
      @(negedge clock);
      chk(active_mode === 2'(m), "mode latched at frame start");
      if (m > 0) chk(frame_len_err === 1'b1, "short frame not flagged");
      for (int l = 2; l < first[m]; l++) hdbp_source_i.line(0, 3, 1);
      @(negedge clock);
      chk(line_len_err === 1'b1, "short line not flagged");
      chk(nv == 0, "blanking line resampled");
      hdbp_source_i.ys.delete();
      hdbp_source_i.line(0, tot[m], act[m]);
      hdbp_source_i.line(0, 3, 0);
      repeat (4) @(posedge clock);
      acc  = 0;
      k    = 0;
      prev = 10'sh000;
      foreach (hdbp_source_i.ys[i]) begin
        s   = {~hdbp_source_i.ys[i][9], hdbp_source_i.ys[i][8:0]};
        acc = acc + num[m];
        if (acc >= num[m] + 1) begin
          e   = acc == num[m] + 1 ? s : 10'((int'(prev) + int'(s)) >>> 1);
          acc = acc - num[m] - 1;
          chk(k < gy.size() && gy[k] === e, "resampled value");
          k++;
        end
        prev = s;
      end
      chk(gy.size() == k && k == act[m] * num[m] / (num[m] + 1), "luma count");
      chk(nc == k / 2, "chroma count");
      $display("test mode %0d done, %0d samples", m, k);
    end
    hdbp_source_i.idle();
    conclude();
  end
endmodule : hdbp_partitioner_test

`default_nettype wire
